// >>> design/fpc_pkg.sv
// Package of constants for the flash protection control block
package fpc_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] FPC_OFF_PPROT   = 8'h00;
  localparam logic [7:0] FPC_OFF_DPROT   = 8'h04;
  localparam logic [7:0] FPC_OFF_STATUS  = 8'h08;
  localparam logic [7:0] FPC_OFF_CMDIDX  = 8'h0C;
  localparam logic [7:0] FPC_OFF_CMDOBJ  = 8'h10;
  localparam logic [7:0] FPC_OFF_REQ     = 8'h14;
  // Program-flash protection field positions
  localparam int FPC_P_OPEN  = 7;
  localparam int FPC_P_RNV   = 6;
  localparam int FPC_P_HDIS  = 5;
  localparam int FPC_P_HS_LO = 3;
  localparam int FPC_P_LDIS  = 2;
  localparam int FPC_P_LS_LO = 0;
  // Data-flash protection field positions
  localparam int FPC_D_DIS   = 7;
  // Fault fallback values
  localparam logic [7:0] FPC_PPROT_FAULT = 8'h7F;
  localparam logic [7:0] FPC_DPROT_FAULT = 8'h0F;
  // Nonvolatile byte addresses
  localparam logic [17:0] FPC_NV_PPROT_ADDR = 18'h3_FF0C;
  localparam logic [17:0] FPC_NV_DPROT_ADDR = 18'h3_FF0D;
  // Memory map
  localparam logic [17:0] FPC_PF_TOP    = 18'h3_FFFF;
  localparam logic [17:0] FPC_PF_BOTTOM = 18'h3_8000;
  localparam logic [17:0] FPC_DF_BASE   = 18'h0_4400;
  localparam int FPC_PF_SECTORS   = 256;
  localparam int FPC_PF_SECT_BYTES = 512;
  localparam int FPC_DF_SECTORS   = 16;
  localparam int FPC_DF_SECT_BYTES = 256;
  localparam int FPC_CMD_WORDS    = 6;
  // Command kinds
  typedef enum logic [1:0] {
    FPC_OP_PROG  = 2'b00,
    FPC_OP_SECT  = 2'b01,
    FPC_OP_BLOCK = 2'b10
  } fpc_op_t;
endpackage : fpc_pkg

// >>> design/fpc_top.sv
// Flash protection control with AXI4-Lite register slave
`timescale 1ns/1ps
module fpc_top #(
  parameter logic [8:0] HS_SECTORS0 = 9'd4,
  parameter logic [8:0] HS_SECTORS1 = 9'd8,
  parameter logic [8:0] HS_SECTORS2 = 9'd16,
  parameter logic [8:0] HS_SECTORS3 = 9'd32,
  parameter logic [8:0] LS_SECTORS0 = 9'd2,
  parameter logic [8:0] LS_SECTORS1 = 9'd4,
  parameter logic [8:0] LS_SECTORS2 = 9'd8,
  parameter logic [8:0] LS_SECTORS3 = 9'd16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // NV protection bytes offered during reset load
  input  wire logic        nv_valid,
  input  wire logic [7:0]  nv_pprot_byte,
  input  wire logic        nv_pprot_dbl_fault,
  input  wire logic [7:0]  nv_dprot_byte,
  input  wire logic        nv_dprot_dbl_fault,
  output logic             nv_load_done,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Check result toward the command engine
  output logic             op_allowed,
  output logic             op_refused
);
  import fpc_pkg::*;

  logic [7:0]  pprot_q;
  logic [7:0]  dprot_q;
  logic        viol_q;
  logic [2:0]  cmd_idx_q;
  logic [15:0] cmd_obj_q [FPC_CMD_WORDS];
  logic        loaded_q;
  logic [31:0] awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic        req_q;
  logic [1:0]  req_op_q;
  logic [17:0] req_addr_q;

  // Reset load of protection bytes; held off until NV data is ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loaded_q     <= 1'b0;
      nv_load_done <= 1'b0;
    end else if (clk_en && !loaded_q && nv_valid) begin
      loaded_q     <= 1'b1;
      nv_load_done <= 1'b1;
    end
  end

  // Bus handshake: write taken when address and data both held
  logic wr_fire;
  logic [7:0] wr_off;
  logic [7:0] wbyte;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid && loaded_q;
  assign wr_off  = awaddr_q[7:0];
  assign wbyte   = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 32'h0000_0000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else if (clk_en) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
        awaddr_q      <= {24'h00_0000, s_axi_awaddr};
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_off > FPC_OFF_REQ || wr_off[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Scenario transition table, row is current, bit is target
  function automatic logic pprot_move_ok(input logic [2:0] from, input logic [2:0] to);
    logic [7:0] row;
    row = 8'h00;
    case (from)
      3'd0:    row = 8'h0F;
      3'd1:    row = 8'h0A;
      3'd2:    row = 8'h0C;
      3'd3:    row = 8'h08;
      3'd4:    row = 8'h18;
      3'd5:    row = 8'h3C;
      3'd6:    row = 8'h5A;
      3'd7:    row = 8'hFF;
      default: row = 8'h00;
    endcase
    return row[to];
  endfunction : pprot_move_ok

  logic [2:0] scen_cur;
  logic [2:0] scen_new;
  logic [7:0] pprot_cand;
  assign scen_cur = {pprot_q[FPC_P_OPEN], pprot_q[FPC_P_HDIS], pprot_q[FPC_P_LDIS]};

  always_comb begin
    pprot_cand = pprot_q;
    pprot_cand[FPC_P_OPEN] = wbyte[FPC_P_OPEN];
    pprot_cand[FPC_P_HDIS] = wbyte[FPC_P_HDIS];
    pprot_cand[FPC_P_LDIS] = wbyte[FPC_P_LDIS];
    if (pprot_q[FPC_P_HDIS])
      pprot_cand[FPC_P_HS_LO +: 2] = wbyte[FPC_P_HS_LO +: 2];
    if (pprot_q[FPC_P_LDIS])
      pprot_cand[FPC_P_LS_LO +: 2] = wbyte[FPC_P_LS_LO +: 2];
  end
  assign scen_new = {pprot_cand[FPC_P_OPEN], pprot_cand[FPC_P_HDIS], pprot_cand[FPC_P_LDIS]};

  // Program-flash protection register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pprot_q <= FPC_PPROT_FAULT;
    end else if (clk_en) begin
      if (!loaded_q && nv_valid) begin
        if (nv_pprot_dbl_fault)
          pprot_q <= FPC_PPROT_FAULT;
        else
          pprot_q <= nv_pprot_byte;
      end else if (wr_fire && wr_off == FPC_OFF_PPROT && wstrb_q[0]) begin
        if (pprot_move_ok(scen_cur, scen_new))
          pprot_q <= pprot_cand;
      end
    end
  end

  // Data-flash protection register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dprot_q <= FPC_DPROT_FAULT;
    end else if (clk_en) begin
      if (!loaded_q && nv_valid) begin
        if (nv_dprot_dbl_fault)
          dprot_q <= FPC_DPROT_FAULT;
        else
          dprot_q <= {nv_dprot_byte[7], 3'b000, nv_dprot_byte[3:0]};
      end else if (wr_fire && wr_off == FPC_OFF_DPROT && wstrb_q[0]) begin
        if (wbyte[3:0] > dprot_q[3:0] && !(wbyte[FPC_D_DIS] && !dprot_q[FPC_D_DIS]))
          dprot_q <= {wbyte[FPC_D_DIS], 3'b000, wbyte[3:0]};
        else if (wbyte[3:0] == dprot_q[3:0] && dprot_q[FPC_D_DIS] && !wbyte[FPC_D_DIS])
          dprot_q[FPC_D_DIS] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_idx_q <= 3'd0;
      for (int i = 0; i < FPC_CMD_WORDS; i++)
        cmd_obj_q[i] <= 16'h0000;
    end else if (clk_en && wr_fire) begin
      if (wr_off == FPC_OFF_CMDIDX && wstrb_q[0])
        cmd_idx_q <= wdata_q[2:0];
      if (wr_off == FPC_OFF_CMDOBJ && cmd_idx_q < 3'(FPC_CMD_WORDS)) begin
        if (wstrb_q[0])
          cmd_obj_q[cmd_idx_q][7:0] <= wdata_q[7:0];
        if (wstrb_q[1])
          cmd_obj_q[cmd_idx_q][15:8] <= wdata_q[15:8];
      end
    end
  end

  // Protection check of a requested operation
  function automatic logic [8:0] hs_sectors(input logic [1:0] code);
    case (code)
      2'd0:    return HS_SECTORS0;
      2'd1:    return HS_SECTORS1;
      2'd2:    return HS_SECTORS2;
      default: return HS_SECTORS3;
    endcase
  endfunction : hs_sectors

  function automatic logic [8:0] ls_sectors(input logic [1:0] code);
    case (code)
      2'd0:    return LS_SECTORS0;
      2'd1:    return LS_SECTORS1;
      2'd2:    return LS_SECTORS2;
      default: return LS_SECTORS3;
    endcase
  endfunction : ls_sectors

  logic        in_pf;
  logic        in_df;
  logic [8:0]  pf_sect;
  logic [4:0]  df_sect;
  logic        in_high;
  logic        in_low;
  logic        pf_prot;
  logic        pf_any;
  logic        df_prot;
  logic        df_any;
  logic        refuse;
  logic [17:0] pf_off;
  logic [17:0] df_off;
  logic [17:0] lo_off;

  // Program flash counted down from its top, so the top region never wraps
  assign pf_off  = FPC_PF_TOP - req_addr_q;
  assign lo_off  = req_addr_q - FPC_PF_BOTTOM;
  assign df_off  = req_addr_q - FPC_DF_BASE;
  assign in_pf   = pf_off < 18'(FPC_PF_SECTORS * FPC_PF_SECT_BYTES);
  assign in_df   = req_addr_q >= FPC_DF_BASE
                && df_off < 18'(FPC_DF_SECTORS * FPC_DF_SECT_BYTES);
  assign pf_sect = {1'b0, pf_off[16:9]};
  assign df_sect = {1'b0, df_off[11:8]};
  assign in_high = !pprot_q[FPC_P_HDIS] && pf_sect < hs_sectors(pprot_q[FPC_P_HS_LO +: 2]);
  assign in_low  = !pprot_q[FPC_P_LDIS] && req_addr_q >= FPC_PF_BOTTOM
                && lo_off[17:9] < ls_sectors(pprot_q[FPC_P_LS_LO +: 2]);
  assign pf_prot = pprot_q[FPC_P_OPEN] ? (in_high || in_low) : !(in_high || in_low);
  assign pf_any  = !pprot_q[FPC_P_OPEN] || !pprot_q[FPC_P_HDIS] || !pprot_q[FPC_P_LDIS];
  assign df_prot = !dprot_q[FPC_D_DIS] && df_sect <= {1'b0, dprot_q[3:0]};
  assign df_any  = !dprot_q[FPC_D_DIS];

  always_comb begin
    refuse = 1'b0;
    if (in_pf) begin
      if (req_op_q == FPC_OP_BLOCK)
        refuse = pf_any;
      else
        refuse = pf_prot;
    end else if (in_df) begin
      if (req_op_q == FPC_OP_BLOCK)
        refuse = df_any;
      else
        refuse = df_prot;
    end
  end

  // Request latch one cycle after the write, verdict one cycle after the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q      <= 1'b0;
      req_op_q   <= 2'b00;
      req_addr_q <= 18'h0_0000;
      op_allowed <= 1'b0;
      op_refused <= 1'b0;
    end else if (clk_en) begin
      req_q      <= wr_fire && wr_off == FPC_OFF_REQ;
      op_allowed <= req_q && !refuse;
      op_refused <= req_q && refuse;
      if (wr_fire && wr_off == FPC_OFF_REQ) begin
        req_addr_q <= wdata_q[17:0];
        req_op_q   <= wdata_q[25:24];
      end
    end
  end

  // Violation flag; set wins over write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      viol_q <= 1'b0;
    end else if (clk_en) begin
      if (req_q && refuse)
        viol_q <= 1'b1;
      else if (wr_fire && wr_off == FPC_OFF_STATUS && wstrb_q[0] && wdata_q[0])
        viol_q <= 1'b0;
    end
  end

  // Read channel
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      FPC_OFF_PPROT:  rd_word = {24'h00_0000, pprot_q};
      FPC_OFF_DPROT:  rd_word = {24'h00_0000, dprot_q};
      FPC_OFF_STATUS: rd_word = {31'h0000_0000, viol_q};
      FPC_OFF_CMDIDX: rd_word = {29'h0000_0000, cmd_idx_q};
      FPC_OFF_CMDOBJ: rd_word = (cmd_idx_q < 3'(FPC_CMD_WORDS))
                                ? {16'h0000, cmd_obj_q[cmd_idx_q]} : 32'h0000_0000;
      FPC_OFF_REQ:    rd_word = {6'h00, req_op_q, 6'h00, req_addr_q};
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (clk_en) begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= (s_axi_araddr > FPC_OFF_REQ || s_axi_araddr[1:0] != 2'b00)
                         ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : fpc_top

// >>> testbench/fpc_chk.sv
// Port checker for the flash protection control block
`timescale 1ns/1ps
module fpc_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        nv_valid,
  input wire logic        nv_load_done,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        op_allowed,
  input wire logic        op_refused
);
  import fpc_pkg::*;
  logic req_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Last taken write address was the check request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      req_q <= (s_axi_awaddr == FPC_OFF_REQ);
    end
  end
  a_pulse_excl: assert property (!(op_allowed && op_refused))
    else $error("allowed and refused together");
  a_op_single: assert property ((op_allowed || op_refused) |=> !(op_allowed || op_refused))
    else $error("check result longer than one cycle");
  a_op_answer: assert property ($rose(s_axi_bvalid) && req_q |-> ##[1:3] (op_allowed || op_refused))
    else $error("check request without result");
  a_no_spur: assert property ((op_allowed || op_refused) |-> req_q)
    else $error("check result without request");
  a_load_first: assert property (nv_valid && !nv_load_done |=> nv_load_done)
    else $error("load missed first valid edge");
  a_load_stays: assert property (nv_load_done |=> nv_load_done)
    else $error("load done dropped");
  a_write_held: assert property (!nv_load_done |-> !s_axi_bvalid)
    else $error("write answered before load");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> s_axi_rvalid)
    else $error("read accepted without data");
  a_slverr_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > FPC_OFF_REQ
    |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  c_refused: cover property (op_refused);
  c_allowed: cover property (op_allowed);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : fpc_chk
bind fpc_top fpc_chk u_chk (.*);

// >>> testbench/fpc_nv_model.sv
// Behavioural model of the nonvolatile protection bytes
`timescale 1ns/1ps
module fpc_nv_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] cfg_pbyte,
  input  wire logic [7:0] cfg_dbyte,
  input  wire logic       cfg_pfault,
  input  wire logic       cfg_dfault,
  output logic            nv_valid,
  output logic [7:0]      nv_pprot_byte,
  output logic            nv_pprot_dbl_fault,
  output logic [7:0]      nv_dprot_byte,
  output logic            nv_dprot_dbl_fault
);
  logic [1:0] wait_q;
  // Array read needs a few cycles after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q <= 2'h0;
    end else if (wait_q != 2'h3) begin
      wait_q <= wait_q + 2'h1;
    end
  end
  assign nv_valid = (wait_q == 2'h3);
  assign nv_pprot_dbl_fault = nv_valid & cfg_pfault;
  assign nv_dprot_dbl_fault = nv_valid & cfg_dfault;
  // Unread lines show the inverse, never the real byte
  assign nv_pprot_byte = nv_valid ? cfg_pbyte : ~cfg_pbyte;
  assign nv_dprot_byte = nv_valid ? cfg_dbyte : ~cfg_dbyte;
endmodule : fpc_nv_model

// >>> testbench/tb_top.sv
// Self-checking bench for the flash protection control block
`timescale 1ns/1ps
module tb_top;
  import fpc_pkg::*;
  localparam logic [7:0]  OK_TO [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
  localparam logic [20:0] OPS [8] = '{21'h13_F800, 21'h07_F7FF, 21'h13_83FF, 21'h03_8400,
                                      21'h1B_9000, 21'h10_47FF, 21'h04_4800, 21'h18_4400};
  logic        aclk, aresetn, nv_valid, nv_pprot_dbl_fault, nv_dprot_dbl_fault, nv_load_done;
  logic        cfg_pfault, cfg_dfault, op_allowed, op_refused, clk_en;
  logic [7:0]  nv_pprot_byte, nv_dprot_byte, cfg_pbyte, cfg_dbyte, pexp, dexp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] lfsr_q;
  int          err_count, checks_done, cyc;

  fpc_top u_dut (.*);
  fpc_nv_model u_nv (.*);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // Scenario move, size fields locked while their range is active
  function automatic logic [7:0] p_next(input logic [7:0] o, input logic [7:0] n);
    if (!OK_TO[{o[7], o[5], o[2]}][{n[7], n[5], n[2]}]) return o;
    // Reserved bit keeps its loaded value
    n[6] = o[6];
    if (!o[5]) n[4:3] = o[4:3];
    if (!o[2]) n[1:0] = o[1:0];
    return n;
  endfunction : p_next

  function automatic logic [7:0] d_next(input logic [7:0] o, input logic [7:0] n);
    n = n & 8'h8F;
    if (n[3:0] > o[3:0] && !(!o[7] && n[7])) return n;
    if (n[3:0] == o[3:0] && o[7] && !n[7]) return n;
    return o;
  endfunction : d_next

  task automatic do_reset(input logic [7:0] p, d, input logic fp, fd);
    @(posedge aclk);
    aresetn    <= 1'b0;
    cfg_pbyte  <= p;
    cfg_dbyte  <= d;
    cfg_pfault <= fp;
    cfg_dfault <= fd;
    pexp = fp ? FPC_PPROT_FAULT : p;
    dexp = fd ? FPC_DPROT_FAULT : (d & 8'h8F);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Registers hold reset values until the NV load
    do begin
      @(posedge aclk);
    end while (!nv_load_done);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk("rdata", rd_data & m, e);
  endtask : rchk

  task automatic opchk(input logic [17:0] a, input logic [1:0] op, input logic no);
    logic seen;
    seen = 1'bx;
    wr(FPC_OFF_REQ, {6'h00, op, 6'h00, a});
    repeat (4) begin
      @(posedge aclk);
      if (op_allowed || op_refused) seen = op_refused;
    end
    chk("op_refused", 32'(seen), 32'(no));
  endtask : opchk

  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    clk_en = 1'b1;
    cfg_pbyte = 8'h00;
    cfg_dbyte = 8'h00;
    cfg_pfault = 1'b0;
    cfg_dfault = 1'b0;
    lfsr_q = 16'hE825;
    do_reset(8'h80, 8'h03, 1'b1, 1'b1);
    rchk(FPC_OFF_PPROT, 32'h0000_00FF, 32'(pexp));
    rchk(FPC_OFF_DPROT, 32'h0000_00FF, 32'(dexp));
    do_reset(8'h80, 8'h03, 1'b0, 1'b0);
    rchk(FPC_OFF_PPROT, 32'h0000_00FF, 32'h0000_0080);
    rchk(FPC_OFF_DPROT, 32'h0000_00FF, 32'h0000_0003);
    foreach (OPS[i]) begin
      opchk(OPS[i][17:0], OPS[i][19:18], OPS[i][20]);
    end
    rchk(FPC_OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr(FPC_OFF_STATUS, 32'h0000_0001);
    rchk(FPC_OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
    wr(FPC_OFF_PPROT, 32'h0000_0024);
    chk("bresp", 32'(wr_resp), 32'h0000_0000);
    rchk(FPC_OFF_PPROT, 32'h0000_00FF, 32'h0000_0024);
    opchk(18'h3_F7FF, 2'h0, 1'b1);
    wr(FPC_OFF_CMDIDX, 32'h0000_0005);
    wr(FPC_OFF_CMDOBJ, 32'h0000_A5C3);
    rchk(FPC_OFF_CMDOBJ, 32'h0000_FFFF, 32'h0000_A5C3);
    wr(FPC_OFF_CMDIDX, 32'h0000_0006);
    rchk(FPC_OFF_CMDOBJ, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h18);
    chk("rresp", 32'(rd_resp), 32'h0000_0002);
    wr(8'h18, 32'h0000_0001);
    chk("bresp", 32'(wr_resp), 32'h0000_0002);
    // Frozen enable must hold off the read answer
    clk_en        <= 1'b0;
    s_axi_araddr  <= FPC_OFF_DPROT;
    s_axi_arvalid <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("frozen", {30'h0000_0000, s_axi_arready, s_axi_rvalid}, 32'h0000_0000);
    clk_en <= 1'b1;
    rchk(FPC_OFF_DPROT, 32'h0000_00FF, 32'(dexp));
    repeat (4) begin
      lfsr_q = lfsr(lfsr_q);
      do_reset(lfsr_q[7:0], lfsr_q[15:8], 1'b0, 1'b0);
      repeat (8) begin
        lfsr_q = lfsr(lfsr_q);
        wr(FPC_OFF_PPROT, {24'h00_0000, lfsr_q[7:0]});
        pexp = p_next(pexp, lfsr_q[7:0]);
        rchk(FPC_OFF_PPROT, 32'h0000_00FF, 32'(pexp));
        wr(FPC_OFF_DPROT, {24'h00_0000, lfsr_q[15:8]});
        dexp = d_next(dexp, lfsr_q[15:8]);
        rchk(FPC_OFF_DPROT, 32'h0000_00FF, 32'(dexp));
      end
    end
    tally_and_finish();
  end
endmodule : tb_top
